// ===== pfws_params.svh
`ifndef PFWS_PARAMS_SVH
`define PFWS_PARAMS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PFWS_MISC_ADDR      8'h81
`define PFWS_DRV_ADDR       8'h82
`define PFWS_BUCKRST_ADDR   8'h87
`define PFWS_RECOV_ADDR     8'hA5
`define PFWS_CFG_ADDR       8'hF0
`define PFWS_STAT_ADDR      8'hF1
// ----------------------------------------------------------------------
// masked write values (a set mask bit keeps the old bit)
// ----------------------------------------------------------------------
`define PFWS_LPM_DATA       8'h04
`define PFWS_LPM_MASK       8'hE3
`define PFWS_BUCK_DATA      8'h1F
`define PFWS_BUCK_MASK      8'hE0
`define PFWS_FDRV_DATA      8'h08
`define PFWS_FDRV_MASK      8'hF7
`define PFWS_RSTC_DATA      8'h00
`define PFWS_RSTC_MASK      8'hFC
`define PFWS_RINC_DATA      8'h01
`define PFWS_RINC_MASK      8'hFE
`define PFWS_SOCF_DATA      8'h18
`define PFWS_SOCF_MASK_P    8'hE1
`define PFWS_SOCF_MASK_S    8'hE3
`define PFWS_LPL_DATA       8'h00
`define PFWS_LPL_MASK       8'hEF
`define PFWS_LPL_SET        8'h10
`define PFWS_FDRV_BIT       3
`define PFWS_LPL_BIT        4
`define PFWS_MRST_BIT       0
`define PFWS_SRST_BIT       1
// ----------------------------------------------------------------------
// times in microseconds and clock rate
// ----------------------------------------------------------------------
`define PFWS_CLK_MHZ        100
`define PFWS_TAIL_US        16000
`define PFWS_WARM_US        2000
`define PFWS_SOCPULSE_US    200
`define PFWS_T1_US          500
`define PFWS_T2_US          2500
`define PFWS_T3_US          3000
`define PFWS_T4_US          3500
`define PFWS_RST_VAL        8'h00
`endif

// ===== pfws_pkg.sv
package pfws_pkg;
    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PFWS_MISSION,     // active / mission standby
        PFWS_TAIL_WAIT,   // orderly or standby tail delay
        PFWS_WARM,        // warm reset in progress
        PFWS_SOCFAULT,    // soc rail power-down
        PFWS_RECOVERY,    // safe recovery
        PFWS_DEEP_SBY     // deep standby
    } pfws_state_t;
endpackage : pfws_pkg

// ===== pfws_sequencer.sv
// The implementer's own choice: the plain strobed port.
`include "pfws_params.svh"
// How it works
// R1: orderly tail waits 16 ms, writes misc
// R2: then buck reset write 0x1F mask 0xE0
// R3: then safe recovery, count compared to threshold
// R4: standby tail: delay on primary, no buck reset
// R5: deep standby select picks deep or mission
// R6: watchdog/mcu error in active starts warm reset
// R7: warm start writes drv, misc, recovery count
// R8: gpio levels untouched during warm reset
// R9: force driver low cleared at warm end
// R10: voltage restore pulse at warm start only
// R11: count over threshold stays in recovery
// R12: soc monitor error pulses soc reset 200us
// R13: soc rail fault drops rails, soc reset on primary only
// R14: soc rails off at 500/2500/3000/3500 us
// R15: ddr retain keeps ddr rails on
// R16: no retain: ddr enable 500us, analog 3000us
// R17: soc fault start writes misc and link enable
// R18: off request ends standby instead of safe
// R19: tails set link enable, primary forces driver
// R20: warm reset outputs release after 2000 us
module pfws_sequencer #(
    parameter int CLK_MHZ  = `PFWS_CLK_MHZ,
    parameter int TAIL_CYC = `PFWS_TAIL_US * CLK_MHZ,
    parameter int RTHR     = 3
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        IS_PRIMARY,
    input  wire logic        ORDERLY_REQ,
    input  wire logic        OFF_REQ,
    input  wire logic        WDOG_ERR,
    input  wire logic        MCU_MON_ERR,
    input  wire logic        SOC_MON_ERR,
    input  wire logic        SOC_RAIL_FAULT,
    input  wire logic        DEEP_SBY_SEL,
    input  wire logic        DDR_RETAIN,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    output logic             MCU_RESET_OUT_N,
    output logic             SOC_RESET_OUT_N,
    output logic             RAM_IO_EN,
    output logic             CORE_CPU_DLL_EN,
    output logic             PHY_PLL_EN,
    output logic             SD_USB_EN,
    output logic             DDR_SUPPLY_ENABLE,
    output logic             DDR_ANALOG_SUPPLY,
    output logic             VOLT_RESTORE,
    output logic             DRIVER_ENABLE_PIN,
    output logic      [2:0]  STATE
);
    // ------------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------------
    localparam int WARM_CYC = `PFWS_WARM_US * CLK_MHZ;
    localparam int SP_CYC   = `PFWS_SOCPULSE_US * CLK_MHZ;
    localparam int T1_CYC   = `PFWS_T1_US * CLK_MHZ;
    localparam int T2_CYC   = `PFWS_T2_US * CLK_MHZ;
    localparam int T3_CYC   = `PFWS_T3_US * CLK_MHZ;
    localparam int T4_CYC   = `PFWS_T4_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic        rst_s1_reg;         // first stage
    logic        rst_n;              // synchronised reset
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    pfws_pkg::pfws_state_t state_reg; // sequencer state
    logic [31:0] cnt_reg;             // sequence timer
    logic [15:0] sp_reg;              // soc pulse timer
    logic        sp_act_reg;          // soc pulse running
    logic        tail_sby_reg;        // tail is standby kind
    logic        ddr_keep_reg;        // latched ddr retain
    logic [7:0]  misc_reg;            // misc output control
    logic [7:0]  drv_reg;             // driver enable status
    logic [7:0]  buck_reg;            // buck reset control
    logic [7:0]  recov_reg;           // recovery count
    logic        restore_reg;         // voltage restore pulse
    logic        sw_wr;               // software write strobe

    // masked write: mask bit one keeps old value
    function automatic logic [7:0] mw(input logic [7:0] old,
                                      input logic [7:0] d,
                                      input logic [7:0] m);
        mw = (old & m) | (d & ~m);
    endfunction : mw

    wire warm_trig = WDOG_ERR | MCU_MON_ERR;
    wire in_mission = (state_reg == pfws_pkg::PFWS_MISSION);
    wire tail_done  = (state_reg == pfws_pkg::PFWS_TAIL_WAIT) &&
                      (cnt_reg >= TAIL_CYC - 1 ||
                       (tail_sby_reg && !IS_PRIMARY)); // see R4
    wire warm_done  = (state_reg == pfws_pkg::PFWS_WARM) &&
                      (cnt_reg == WARM_CYC - 1);
    wire soc_done   = (state_reg == pfws_pkg::PFWS_SOCFAULT) &&
                      (cnt_reg == T4_CYC - 1);
    wire warm_start = in_mission && !tail_sby_reg && warm_trig;
    wire soc_start  = in_mission && SOC_RAIL_FAULT;
    wire tail_start = in_mission && (ORDERLY_REQ || OFF_REQ);
    assign sw_wr = REG_WR && in_mission;

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= pfws_pkg::PFWS_MISSION;
            tail_sby_reg <= 1'b0;
            ddr_keep_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                pfws_pkg::PFWS_MISSION: begin
                    if (warm_start) begin
                        state_reg <= pfws_pkg::PFWS_WARM; // see R6
                    end else if (soc_start) begin
                        state_reg    <= pfws_pkg::PFWS_SOCFAULT;
                        ddr_keep_reg <= DDR_RETAIN; // see R15
                    end else if (tail_start) begin
                        state_reg    <= pfws_pkg::PFWS_TAIL_WAIT;
                        tail_sby_reg <= !ORDERLY_REQ; // see R18
                    end
                end
                pfws_pkg::PFWS_TAIL_WAIT: begin
                    if (tail_done && !tail_sby_reg) begin
                        state_reg <= pfws_pkg::PFWS_RECOVERY; // see R3
                    end else if (tail_done) begin
                        // see R5
                        state_reg <= DEEP_SBY_SEL ?
                                     pfws_pkg::PFWS_DEEP_SBY :
                                     pfws_pkg::PFWS_MISSION;
                    end
                end
                pfws_pkg::PFWS_WARM: begin
                    if (warm_done) begin
                        // see R11
                        state_reg <= (recov_reg > 8'(RTHR)) ?
                                     pfws_pkg::PFWS_RECOVERY :
                                     pfws_pkg::PFWS_MISSION;
                    end
                end
                pfws_pkg::PFWS_SOCFAULT: begin
                    if (soc_done) begin
                        state_reg <= pfws_pkg::PFWS_MISSION;
                    end
                end
                pfws_pkg::PFWS_RECOVERY: begin
                    // recovery proceeds if count within threshold
                    if (recov_reg <= 8'(RTHR)) begin // see R3
                        state_reg <= pfws_pkg::PFWS_MISSION;
                    end
                end
                pfws_pkg::PFWS_DEEP_SBY: begin
                    state_reg <= pfws_pkg::PFWS_DEEP_SBY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // sequence timer
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0000_0000;
        end else if (in_mission || tail_done || warm_done || soc_done) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_reg != pfws_pkg::PFWS_RECOVERY &&
                     state_reg != pfws_pkg::PFWS_DEEP_SBY) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // soc monitor reset pulse, rails untouched
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg     <= 16'h0000;
            sp_act_reg <= 1'b0;
        end else if (SOC_MON_ERR && in_mission && !sp_act_reg) begin
            sp_act_reg <= 1'b1; // see R12
            sp_reg     <= 16'h0000;
        end else if (sp_act_reg) begin
            sp_reg <= sp_reg + 16'h0001;
            if (sp_reg == 16'(SP_CYC - 1)) begin
                sp_act_reg <= 1'b0; // see R12
            end
        end
    end

    // ------------------------------------------------------------------
    // registers: sequence writes win over software
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            misc_reg  <= `PFWS_RST_VAL | 8'h03;
            drv_reg   <= `PFWS_RST_VAL;
            buck_reg  <= `PFWS_RST_VAL;
            recov_reg <= `PFWS_RST_VAL;
        end else if (warm_start) begin
            // see R7
            drv_reg   <= mw(drv_reg, `PFWS_FDRV_DATA, `PFWS_FDRV_MASK);
            misc_reg  <= mw(misc_reg, `PFWS_RSTC_DATA, `PFWS_RSTC_MASK);
            recov_reg <= recov_reg + `PFWS_RINC_DATA;
        end else if (soc_start) begin
            // see R17
            misc_reg <= mw(misc_reg, `PFWS_SOCF_DATA,
                           IS_PRIMARY ? `PFWS_SOCF_MASK_P
                                      : `PFWS_SOCF_MASK_S);
            drv_reg  <= mw(drv_reg, `PFWS_LPL_DATA, `PFWS_LPL_MASK);
        end else if (tail_start) begin
            // see R19
            drv_reg <= drv_reg | `PFWS_LPL_SET |
                       (IS_PRIMARY ? `PFWS_FDRV_DATA : 8'h00);
        end else if (tail_done) begin
            // see R1
            misc_reg <= mw(misc_reg, `PFWS_LPM_DATA, `PFWS_LPM_MASK);
            if (!tail_sby_reg) begin
                buck_reg <= mw(buck_reg, `PFWS_BUCK_DATA,
                               `PFWS_BUCK_MASK); // see R2
                recov_reg <= recov_reg + `PFWS_RINC_DATA; // see R3
            end
        end else if (warm_done) begin
            // see R9 see R20
            drv_reg  <= drv_reg & ~`PFWS_FDRV_DATA;
            misc_reg <= misc_reg | 8'h03;
        end else if (soc_done) begin
            misc_reg <= misc_reg | 8'h02;
        end else if (sw_wr) begin
            unique case (REG_ADDR)
                `PFWS_MISC_ADDR:    misc_reg  <= REG_WDATA;
                `PFWS_DRV_ADDR:     drv_reg   <= REG_WDATA;
                `PFWS_BUCKRST_ADDR: buck_reg  <= REG_WDATA;
                `PFWS_RECOV_ADDR:   recov_reg <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // voltage restore pulse at warm start only
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            restore_reg <= 1'b0;
        end else begin
            restore_reg <= warm_start; // see R10
        end
    end

    // ------------------------------------------------------------------
    // read port, data one cycle later
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `PFWS_MISC_ADDR:    REG_RDATA <= misc_reg;
                `PFWS_DRV_ADDR:     REG_RDATA <= drv_reg;
                `PFWS_BUCKRST_ADDR: REG_RDATA <= buck_reg;
                `PFWS_RECOV_ADDR:   REG_RDATA <= recov_reg;
                `PFWS_STAT_ADDR:    REG_RDATA <= {5'h00, state_reg};
                default:            REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // rail enables and reset outputs
    // ------------------------------------------------------------------
    wire soc_run = (state_reg == pfws_pkg::PFWS_SOCFAULT);
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RAM_IO_EN         <= 1'b1;
            CORE_CPU_DLL_EN   <= 1'b1;
            PHY_PLL_EN        <= 1'b1;
            SD_USB_EN         <= 1'b1;
            DDR_SUPPLY_ENABLE <= 1'b1;
            DDR_ANALOG_SUPPLY <= 1'b1;
        end else if (soc_run) begin
            // see R13 see R14
            if (cnt_reg == T1_CYC - 1) RAM_IO_EN <= 1'b0;
            if (cnt_reg == T2_CYC - 1) CORE_CPU_DLL_EN <= 1'b0;
            if (cnt_reg == T3_CYC - 1) PHY_PLL_EN <= 1'b0;
            if (cnt_reg == T4_CYC - 1) SD_USB_EN <= 1'b0;
            // see R16
            if (!ddr_keep_reg && cnt_reg == T1_CYC - 1)
                DDR_SUPPLY_ENABLE <= 1'b0;
            if (!ddr_keep_reg && cnt_reg == T3_CYC - 1)
                DDR_ANALOG_SUPPLY <= 1'b0;
        end
    end

    // see R6 see R8
    assign MCU_RESET_OUT_N   = misc_reg[`PFWS_MRST_BIT];
    assign SOC_RESET_OUT_N   = misc_reg[`PFWS_SRST_BIT] && !sp_act_reg;
    assign VOLT_RESTORE      = restore_reg;
    assign DRIVER_ENABLE_PIN = !drv_reg[`PFWS_FDRV_BIT];
    assign STATE             = state_reg;
endmodule : pfws_sequencer

// ===== pfws_sequencer_asserts.sv
// ----------------------------------------------------------------------
// port-level checker for the sequencer
// ----------------------------------------------------------------------
`include "pfws_params.svh"
module pfws_sequencer_asserts #(
    parameter int CLK_MHZ = `PFWS_CLK_MHZ  // tick rate of the time base
) (
    input wire logic       SYS_CLK,
    input wire logic       RESET_N,
    input wire logic       IS_PRIMARY,
    input wire logic       DDR_RETAIN,
    input wire logic       MCU_RESET_OUT_N,
    input wire logic       SOC_RESET_OUT_N,
    input wire logic       RAM_IO_EN,
    input wire logic       CORE_CPU_DLL_EN,
    input wire logic       DDR_SUPPLY_ENABLE,
    input wire logic       VOLT_RESTORE,
    input wire logic       DRIVER_ENABLE_PIN,
    input wire logic [2:0] STATE
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WARM_N = `PFWS_WARM_US * CLK_MHZ;     // warm low cycles
    localparam int SP_N   = `PFWS_SOCPULSE_US * CLK_MHZ; // soc pulse cycles
    localparam int T1_N   = `PFWS_T1_US * CLK_MHZ;       // first rail step
    logic        in_warm;   // warm reset running
    logic        in_flt;    // soc rail power-down running
    logic        in_msn;    // mission state
    logic [19:0] mlo_cnt;   // cycles mcu reset has been low
    logic [19:0] slo_cnt;   // cycles soc reset has been low
    logic [19:0] flt_cnt;   // cycles since soc fault entry
    assign in_warm = STATE == pfws_pkg::PFWS_WARM;
    assign in_flt  = STATE == pfws_pkg::PFWS_SOCFAULT;
    assign in_msn  = STATE == pfws_pkg::PFWS_MISSION;
    // low-time and fault-time counters, cleared when idle
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mlo_cnt <= 20'h00000;
            slo_cnt <= 20'h00000;
            flt_cnt <= 20'h00000;
        end else begin
            mlo_cnt <= MCU_RESET_OUT_N ? 20'h00000 : mlo_cnt + 20'h00001;
            slo_cnt <= SOC_RESET_OUT_N ? 20'h00000 : slo_cnt + 20'h00001;
            flt_cnt <= in_flt ? flt_cnt + 20'h00001 : 20'h00000;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    a_warm_resets: assert property (
        $rose(in_warm) |-> !MCU_RESET_OUT_N && !SOC_RESET_OUT_N)
        else $error("reset outputs not low at warm start");
    a_warm_driver: assert property (
        $rose(in_warm) && IS_PRIMARY |-> !DRIVER_ENABLE_PIN)
        else $error("driver not forced low at warm start");
    a_restore_start: assert property (
        VOLT_RESTORE |-> in_warm && !$past(in_warm))
        else $error("voltage restore outside warm start");
    a_warm_release: assert property (
        $rose(MCU_RESET_OUT_N) && $past(in_warm)
        |-> mlo_cnt >= 20'(WARM_N - 2) && mlo_cnt <= 20'(WARM_N + 2))
        else $error("warm reset low time wrong");
    a_warm_end_drv: assert property (
        $fell(in_warm) |-> DRIVER_ENABLE_PIN)
        else $error("driver force not cleared at warm end");
    a_soc_pulse: assert property (
        $rose(SOC_RESET_OUT_N) && $past(in_msn)
        |-> slo_cnt >= 20'(SP_N - 2) && slo_cnt <= 20'(SP_N + 2))
        else $error("soc reset pulse width wrong");
    a_rails_hold: assert property (
        $fell(RAM_IO_EN) || $fell(CORE_CPU_DLL_EN) || $fell(DDR_SUPPLY_ENABLE)
        |-> $past(in_flt))
        else $error("rail dropped outside soc fault");
    a_fault_reset: assert property (
        $rose(in_flt) && IS_PRIMARY |-> !SOC_RESET_OUT_N && MCU_RESET_OUT_N)
        else $error("soc fault reset outputs wrong");
    a_ram_off: assert property (
        $fell(RAM_IO_EN)
        |-> flt_cnt >= 20'(T1_N - 3) && flt_cnt <= 20'(T1_N + 3))
        else $error("ram and io rails off at wrong time");
    a_ddr_off: assert property (
        $fell(DDR_SUPPLY_ENABLE) |-> !DDR_RETAIN && !RAM_IO_EN)
        else $error("ddr supply off with retain set");
    c_warm: cover property ($rose(in_warm));
    c_fault: cover property ($fell(RAM_IO_EN));
    c_pulse: cover property ($rose(SOC_RESET_OUT_N) && $past(in_msn));
endmodule : pfws_sequencer_asserts
bind pfws_sequencer pfws_sequencer_asserts #(.CLK_MHZ(CLK_MHZ))
    u_pfws_sequencer_asserts (.*);

// ===== pfws_soc_model.sv
// ----------------------------------------------------------------------
// processor model: raises error events, times the reset lows
// ----------------------------------------------------------------------
module pfws_soc_model (
    input  wire logic        clk,
    input  wire logic [3:0]  ev,
    input  wire logic        mcu_rst_n,
    input  wire logic        soc_rst_n,
    output logic      [3:0]  err,
    output logic      [19:0] mlo,
    output logic      [19:0] slo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] mcnt;  // running mcu low count
    logic [19:0] scnt;  // running soc low count
    initial begin
        err  = 4'h0;
        mlo  = 20'h00000;
        slo  = 20'h00000;
        mcnt = 20'h00000;
        scnt = 20'h00000;
    end
    // events: watchdog, mcu monitor, soc monitor, rail fault
    always @(posedge clk) begin
        err  <= ev;
        mcnt <= mcu_rst_n ? 20'h00000 : mcnt + 20'h00001;
        scnt <= soc_rst_n ? 20'h00000 : scnt + 20'h00001;
        if (mcu_rst_n && mcnt != 20'h00000) mlo <= mcnt;
        if (soc_rst_n && scnt != 20'h00000) slo <= scnt;
    end
endmodule : pfws_soc_model

// ===== tb_top.sv
`include "pfws_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 100;  // shortened tail delay
    localparam int MHZ = 2;   // scaled time base keeps the run short
    localparam int SPN = `PFWS_SOCPULSE_US * MHZ;
    localparam int WN  = `PFWS_WARM_US * MHZ;
    localparam int T1N = `PFWS_T1_US * MHZ;
    localparam int T4N = `PFWS_T4_US * MHZ;
    logic clk, rst_n, prim, orq, offq, dsel, ret, wr, rd;
    logic [7:0] addr, wdata, rdata;
    logic mrst, srst, ram, core, phy, sd, ddr, ddra, vres, pin;
    logic [2:0] st;
    logic [3:0] ev, err;
    logic [19:0] mlo, slo;
    int error_cnt = 0;
    int tests_run = 0;
    pfws_sequencer #(.CLK_MHZ(MHZ), .TAIL_CYC(TC), .RTHR(3)) u_pfws_sequencer (
        .SYS_CLK(clk), .RESET_N(rst_n), .IS_PRIMARY(prim),
        .ORDERLY_REQ(orq), .OFF_REQ(offq), .WDOG_ERR(err[0]),
        .MCU_MON_ERR(err[1]), .SOC_MON_ERR(err[2]), .SOC_RAIL_FAULT(err[3]),
        .DEEP_SBY_SEL(dsel), .DDR_RETAIN(ret), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .MCU_RESET_OUT_N(mrst), .SOC_RESET_OUT_N(srst), .RAM_IO_EN(ram),
        .CORE_CPU_DLL_EN(core), .PHY_PLL_EN(phy), .SD_USB_EN(sd),
        .DDR_SUPPLY_ENABLE(ddr), .DDR_ANALOG_SUPPLY(ddra),
        .VOLT_RESTORE(vres), .DRIVER_ENABLE_PIN(pin), .STATE(st));
    pfws_soc_model u_pfws_soc_model (.clk(clk), .ev(ev), .mcu_rst_n(mrst),
        .soc_rst_n(srst), .err(err), .mlo(mlo), .slo(slo));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    // read data stands only in the cycle after the strobe
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(rdata, exp);
    endtask : rd8
    task automatic do_reset(input logic p);
        rst_n <= 1'b0;
        {prim, orq, offq, dsel, ret, wr, rd, ev} <= {p, 10'h000};
        {addr, wdata} <= 16'h0000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset
    task automatic fire(input int i);
        @(posedge clk);
        ev <= 4'h1 << i;
        @(posedge clk);
        ev <= 4'h0;
    endtask : fire
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        do_reset(1'b1);
        rd8(`PFWS_MISC_ADDR, 8'h03);
        rd8(`PFWS_DRV_ADDR, `PFWS_RST_VAL);
        rd8(`PFWS_BUCKRST_ADDR, `PFWS_RST_VAL);
        rd8(`PFWS_RECOV_ADDR, `PFWS_RST_VAL);
        rd8(`PFWS_CFG_ADDR, 8'h00);
        chk1(pin, 1'b1);
        fire(2);
        repeat (SPN + 10) @(posedge clk);
        chk8(slo[7:0], 8'(SPN));
        chk8(slo[15:8], 8'(SPN >> 8));
        chk8({4'h0, slo[19:16]}, 8'(SPN >> 16));
        chk1(mrst & ram & core, 1'b1);
    endtask : t_regs
    task automatic t_warm();
        do_reset(1'b1);
        wr8(`PFWS_MISC_ADDR, 8'hE7);
        fire(1);
        repeat (2) @(posedge clk);
        chk8({5'h00, st}, {5'h00, pfws_pkg::PFWS_WARM});
        rd8(`PFWS_MISC_ADDR, 8'hE4);
        rd8(`PFWS_DRV_ADDR, 8'h08);
        rd8(`PFWS_RECOV_ADDR, 8'h01);
        wr8(`PFWS_MISC_ADDR, 8'hFF);
        rd8(`PFWS_MISC_ADDR, 8'hE4);
        do_reset(1'b1);
        chk1(mrst, 1'b1);
        wr8(`PFWS_RECOV_ADDR, 8'h03);
        fire(0);
        repeat (WN + 20) @(posedge clk);
        chk8({5'h00, st}, {5'h00, pfws_pkg::PFWS_RECOVERY});
        chk8(mlo[7:0], 8'(WN));
        chk8(mlo[15:8], 8'(WN >> 8));
        chk1(mrst & srst & ram & core, 1'b1);
        rd8(`PFWS_DRV_ADDR, 8'h00);
        rd8(`PFWS_RECOV_ADDR, 8'h04);
        chk1(pin, 1'b1);
    endtask : t_warm
    // tail of orderly or standby sequence; early read shows the delay on primary, its absence on a secondary standby tail
    task automatic t_tail(input logic p, input logic o, input logic d,
            input logic [2:0] es, input logic [7:0] edrv, input logic [7:0] eb);
        do_reset(p);
        dsel <= d;
        wr8(`PFWS_MISC_ADDR, 8'hFB);
        @(posedge clk);
        {orq, offq} <= {o, !o};
        @(posedge clk);
        {orq, offq} <= 2'b00;
        repeat (p ? TC / 2 : 8) @(posedge clk);
        rd8(`PFWS_MISC_ADDR, p ? 8'hFB : 8'hE7);
        repeat (TC + 20) @(posedge clk);
        rd8(`PFWS_MISC_ADDR, 8'hE7);
        rd8(`PFWS_BUCKRST_ADDR, eb);
        rd8(`PFWS_RECOV_ADDR, {7'h00, o});
        rd8(`PFWS_DRV_ADDR, edrv);
        chk8({5'h00, st}, {5'h00, es});
    endtask : t_tail
    task automatic t_fault(input logic r);
        int n;
        do_reset(!r);
        ret <= r;
        wr8(`PFWS_DRV_ADDR, 8'h10);
        fire(3);
        repeat (2) @(posedge clk);
        rd8(`PFWS_MISC_ADDR, r ? 8'h1B : 8'h19);
        rd8(`PFWS_DRV_ADDR, 8'h00);
        chk1(srst === r && mrst, 1'b1);
        n = 0;
        while (ram === 1'b1 && n < T1N + 100) begin
            @(posedge clk);
            n++;
        end
        chk1(n > T1N - 100 && n < T1N, 1'b1);
        #1 chk1(ddr, r);
        chk1(core && ddra, 1'b1);
        repeat (T4N - T1N + 10) @(posedge clk);
        chk1(core | phy | sd, 1'b0);
        chk1(ddra, r);
        chk1(mrst, 1'b1);
    endtask : t_fault
    task automatic end_sim();
        $display("errors %0d, comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // watchdog sized above the longest expected run
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
    initial begin
        t_regs();
        t_warm();
        t_tail(1'b1, 1'b1, 1'b0, pfws_pkg::PFWS_MISSION, 8'h18, 8'h1F);
        t_tail(1'b0, 1'b0, 1'b1, pfws_pkg::PFWS_DEEP_SBY, 8'h10, 8'h00);
        t_tail(1'b1, 1'b0, 1'b0, pfws_pkg::PFWS_MISSION, 8'h18, 8'h00);
        t_fault(1'b0);
        t_fault(1'b1);
        end_sim();
    end
endmodule : tb_top
